// *** dma_flags_pkg.sv ***
/*
  Shared constants and types for the DMA channel flag and control block:
  register offsets, flag and control field layouts, reset values.
  Assumes a single synchronous clock and five channels.
*/
// Operation
// - Error flag set per channel, sticky.
// - Half-transfer flag set per channel, sticky.
// - Full-transfer flag set per channel, sticky.
// - Global flag is OR of three flags.
// - Flag register read-only, offset zero, upper zero.
// - Writing one clears error flag.
// - Writing one clears half-transfer flag.
// - Writing one clears full-transfer flag.
// - Global clear bit clears all four flags.
// - Control registers at eight plus channel step.
// - Bit 14 selects memory-to-memory mode.
// - Bits 13:12 hold channel priority, locked.
// - Bits 11:10 select memory width.
// - Bits 9:8 select peripheral width.
// - Bit 7 enables memory address increment.
// - Bit 6 enables peripheral address increment.
// - Bit 5 enables circular mode.
// - Settings ignore writes while channel enabled.
// - Bit 4 selects direction, locked when enabled.
// - Bits 3:1 enable interrupts, bit 0 enables.
// - Channel interrupt on enabled flagged event.

package dma_flags_pkg;

  // ==========================================================================
  // Sizes and offsets
  localparam int         N_CHANNELS  = 5;
  localparam int         ADDR_W      = 8;
  localparam int         FLAG_STRIDE = 4;
  localparam int         CTL_USED    = 15;
  localparam logic [7:0] FLAGS_OFS   = 8'h00;
  localparam logic [7:0] CLEAR_OFS   = 8'h04;
  localparam logic [7:0] CTL_BASE    = 8'h08;
  localparam logic [7:0] CTL_STEP    = 8'h14;

  // ==========================================================================
  // Reset values and masks
  localparam logic [3:0]  FLAG_RESET    = 4'h0;
  localparam logic [14:0] CTL_RESET     = 15'h0000;
  localparam logic [14:0] CTL_LOCK_MASK = 15'h7ff0;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  // ==========================================================================
  // One channel's flags, laid out as its nibble of the flag word.
  typedef struct packed {
    logic error_flag;
    logic half_done_flag;
    logic full_done_flag;
    logic global_flag;
  } flags_s;

  // One channel's control bits 14:0, in register order.
  typedef struct packed {
    logic       mem_to_mem_select;
    logic [1:0] channel_priority;
    logic [1:0] memory_width;
    logic [1:0] peripheral_width;
    logic       memory_increment;
    logic       peripheral_increment;
    logic       circular_enable;
    logic       direction;
    logic       error_irq_enable;
    logic       half_done_irq_enable;
    logic       full_done_irq_enable;
    logic       channel_enable;
  } ctl_s;

  // Bus-facing state of the top module.
  typedef struct packed {
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [N_CHANNELS-1:0] irq;
  } apb_state_s;

endpackage : dma_flags_pkg

// *** dma_channel_flags.sv ***
/*
  Sticky event flags of one DMA channel with write-one-to-clear.
  Assumes event pulses and clear strobes come from logic on clk.
*/
`timescale 1ns/10ps

module dma_channel_flags (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  error_event,
  input  wire logic                  half_event,
  input  wire logic                  full_event,
  input  wire dma_flags_pkg::flags_s clear,
  output dma_flags_pkg::flags_s      flags
);

  dma_flags_pkg::flags_s state;
  dma_flags_pkg::flags_s next_state;

  // ==========================================================================
  // Set wins over clear; the global clear drops every flag of the channel.
  always_comb
  begin
    next_state.error_flag     = error_event |
      (state.error_flag & ~clear.error_flag & ~clear.global_flag);
    next_state.half_done_flag = half_event |
      (state.half_done_flag & ~clear.half_done_flag & ~clear.global_flag);
    next_state.full_done_flag = full_event |
      (state.full_done_flag & ~clear.full_done_flag & ~clear.global_flag);
    next_state.global_flag    = next_state.error_flag | next_state.half_done_flag |
      next_state.full_done_flag;
  end

  // Flag storage.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= dma_flags_pkg::FLAG_RESET;
    else
      state <= next_state;
  end

  assign flags = state;

endmodule : dma_channel_flags

// *** dma_channel_ctl.sv ***
/*
  Control register of one DMA channel with the enable lock.
  Assumes the write strobe is a single cycle on clk.
*/
`timescale 1ns/10ps

module dma_channel_ctl (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                write,
  input  wire dma_flags_pkg::ctl_s wdata,
  output dma_flags_pkg::ctl_s      ctl
);

  dma_flags_pkg::ctl_s state;
  dma_flags_pkg::ctl_s next_state;

  // ==========================================================================
  // While enabled only the interrupt enables and the enable bit take writes.
  always_comb
  begin
    next_state = state;
    if (write && state.channel_enable)
      next_state = (state & dma_flags_pkg::CTL_LOCK_MASK) |
                   (wdata & ~dma_flags_pkg::CTL_LOCK_MASK);
    else if (write)
      next_state = wdata;
  end

  // Control storage.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= dma_flags_pkg::CTL_RESET;
    else
      state <= next_state;
  end

  assign ctl = state;

endmodule : dma_channel_ctl

// *** dma_flags_ctrl.sv ***
/*
  APB slave holding the flag, flag-clear and per-channel control
  registers of a five-channel DMA controller, plus per-channel interrupts.
  Assumes the transfer engine sends single-cycle event pulses on clk and
  reads the channel settings from channel_config.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/10ps

module dma_flags_ctrl (
  input  wire logic                                           clk,
  input  wire logic                                           rst_b,
  input  wire logic                                           psel,
  input  wire logic                                           penable,
  input  wire logic                                           pwrite,
  input  wire logic [dma_flags_pkg::ADDR_W-1:0]               paddr,
  input  wire logic [31:0]                                    pwdata,
  output logic [31:0]                                         prdata,
  output logic                                                pready,
  output logic                                                pslverr,
  input  wire logic [dma_flags_pkg::N_CHANNELS-1:0]           error_event,
  input  wire logic [dma_flags_pkg::N_CHANNELS-1:0]           half_event,
  input  wire logic [dma_flags_pkg::N_CHANNELS-1:0]           full_event,
  output dma_flags_pkg::ctl_s [dma_flags_pkg::N_CHANNELS-1:0] channel_config,
  output logic [dma_flags_pkg::N_CHANNELS-1:0]                channel_irq
);

  localparam int N = dma_flags_pkg::N_CHANNELS;

  dma_flags_pkg::apb_state_s state;
  dma_flags_pkg::apb_state_s next_state;
  dma_flags_pkg::flags_s     flags     [N];
  dma_flags_pkg::flags_s     clear     [N];
  dma_flags_pkg::ctl_s       ctl       [N];
  logic                      hit_flags;
  logic                      hit_clear;
  logic [N-1:0]              hit_ctl;
  logic                      hit_any;
  logic                      done;
  logic [N-1:0]              ctl_write;
  logic [N-1:0]              irq_calc;
  logic [31:0]               read_word;

  // ==========================================================================
  // Address of a channel's control register.
  function automatic logic [7:0] ctl_addr(input int idx);
    ctl_addr = 8'(dma_flags_pkg::CTL_BASE + dma_flags_pkg::CTL_STEP * 8'(idx));
  endfunction : ctl_addr

  // ==========================================================================
  // Address decode. Unmapped words, including the counter and address
  // registers kept elsewhere, answer with an error.
  always_comb
  begin
    hit_flags = 1'b0;
    hit_clear = 1'b0;
    hit_ctl   = '0;
    if (paddr == dma_flags_pkg::FLAGS_OFS)
      hit_flags = 1'b1;
    else if (paddr == dma_flags_pkg::CLEAR_OFS)
      hit_clear = 1'b1;
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (paddr == ctl_addr(i))
          hit_ctl[i] = 1'b1;
      end
    end
  end

  assign hit_any = hit_flags | hit_clear | (|hit_ctl);

  // A transfer completes at the edge that sees the access phase with pready.
  // Only whole words are written; there are no byte strobes.
  assign done = psel & penable & state.pready;

  // ==========================================================================
  // Read data. The clear register is write-only and reads zero; reserved
  // bits above the used fields read zero.
  always_comb
  begin
    read_word = dma_flags_pkg::WORD_ZERO;
    if (hit_flags)
    begin
      for (int i = 0; i < N; i++)
        read_word[i*dma_flags_pkg::FLAG_STRIDE +: dma_flags_pkg::FLAG_STRIDE] = flags[i];
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (hit_ctl[i])
          read_word[dma_flags_pkg::CTL_USED-1:0] = ctl[i];
      end
    end
  end

  // ==========================================================================
  // Per-channel flags, control registers and write strobes.
  generate
    for (genvar g = 0; g < N; g++)
    begin : g_chan
      assign clear[g]     = (done && pwrite && hit_clear) ?
        dma_flags_pkg::flags_s'(pwdata[g*dma_flags_pkg::FLAG_STRIDE +: dma_flags_pkg::FLAG_STRIDE]) :
        dma_flags_pkg::flags_s'(dma_flags_pkg::FLAG_RESET);
      assign ctl_write[g] = done & pwrite & hit_ctl[g];
      assign irq_calc[g]  = (flags[g].error_flag & ctl[g].error_irq_enable) |
                            (flags[g].half_done_flag & ctl[g].half_done_irq_enable) |
                            (flags[g].full_done_flag & ctl[g].full_done_irq_enable);
      assign channel_config[g] = ctl[g];

      dma_channel_flags u_flags (
        .clk         (clk),
        .rst_b       (rst_b),
        .error_event (error_event[g]),
        .half_event  (half_event[g]),
        .full_event  (full_event[g]),
        .clear       (clear[g]),
        .flags       (flags[g])
      );

      dma_channel_ctl u_ctl (
        .clk   (clk),
        .rst_b (rst_b),
        .write (ctl_write[g]),
        .wdata (dma_flags_pkg::ctl_s'(pwdata[dma_flags_pkg::CTL_USED-1:0])),
        .ctl   (ctl[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Bus answer: read data and error are captured in the setup cycle, so
  // every access completes in its first access cycle.
  always_comb
  begin
    next_state         = state;
    next_state.pready  = psel & ~penable;
    next_state.pslverr = psel & ~penable & ~hit_any;
    next_state.prdata  = (psel && !penable && !pwrite) ? read_word : dma_flags_pkg::WORD_ZERO;
    next_state.irq     = irq_calc;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= '0;
    else
      state <= next_state;
  end

  assign prdata      = state.prdata;
  assign pready      = state.pready;
  assign pslverr     = state.pslverr;
  assign channel_irq = state.irq;

  // ==========================================================================
  // Checks on the block's own behaviour.
  logic [N-1:0] err_vec;
  logic [N-1:0] half_vec;
  logic [N-1:0] full_vec;
  logic [N-1:0] glob_vec;
  logic [N-1:0] clr_err;
  logic [N-1:0] clr_half;
  logic [N-1:0] clr_full;

  // Flattened flag and clear vectors for the checks.
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      err_vec[i]  = flags[i].error_flag;
      half_vec[i] = flags[i].half_done_flag;
      full_vec[i] = flags[i].full_done_flag;
      glob_vec[i] = flags[i].global_flag;
      clr_err[i]  = clear[i].error_flag | clear[i].global_flag;
      clr_half[i] = clear[i].half_done_flag | clear[i].global_flag;
      clr_full[i] = clear[i].full_done_flag | clear[i].global_flag;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_err_set;
    (error_event != '0) |=> ((err_vec & $past(error_event)) == $past(error_event));
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error flag not set by its event");

  property p_half_set;
    (half_event != '0) |=> ((half_vec & $past(half_event)) == $past(half_event));
  endproperty
  a_half_set: assert property (p_half_set)
    else $error("half-transfer flag not set by its event");

  property p_full_set;
    (full_event != '0) |=> ((full_vec & $past(full_event)) == $past(full_event));
  endproperty
  a_full_set: assert property (p_full_set)
    else $error("full-transfer flag not set by its event");

  property p_global_or;
    glob_vec == (err_vec | half_vec | full_vec);
  endproperty
  a_global_or: assert property (p_global_or)
    else $error("global flag differs from OR of channel flags");

  property p_flag_read;
    (psel && !penable && !pwrite && paddr == dma_flags_pkg::FLAGS_OFS) |=>
      (pready && prdata[31:20] == 12'h000 && prdata[19:0] == $past(read_word[19:0]));
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag register read returned wrong data");

  property p_err_clear;
    ((clr_err & ~error_event) != '0) |=> ((err_vec & $past(clr_err & ~error_event)) == '0);
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error flag survived its clear");

  property p_half_clear;
    ((clr_half & ~half_event) != '0) |=> ((half_vec & $past(clr_half & ~half_event)) == '0);
  endproperty
  a_half_clear: assert property (p_half_clear)
    else $error("half-transfer flag survived its clear");

  property p_full_clear;
    ((clr_full & ~full_event) != '0) |=> ((full_vec & $past(clr_full & ~full_event)) == '0);
  endproperty
  a_full_clear: assert property (p_full_clear)
    else $error("full-transfer flag survived its clear");

  property p_flag_hold;
    ((err_vec & ~clr_err) != '0) |=> ((err_vec & $past(err_vec & ~clr_err)) == $past(err_vec & ~clr_err));
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("error flag dropped without a clear");

  property p_ctl_lock;
    (done && pwrite && hit_ctl[0] && ctl[0].channel_enable) |=>
      ((ctl[0] & dma_flags_pkg::CTL_LOCK_MASK) == $past(ctl[0] & dma_flags_pkg::CTL_LOCK_MASK));
  endproperty
  a_ctl_lock: assert property (p_ctl_lock)
    else $error("locked control setting changed while enabled");

  property p_ctl_write;
    (done && pwrite && hit_ctl[N-1] && !ctl[N-1].channel_enable) |=>
      (channel_config[N-1] == $past(pwdata[dma_flags_pkg::CTL_USED-1:0]));
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write to disabled channel not stored");

  property p_irq;
    channel_irq == $past(irq_calc);
  endproperty
  a_irq: assert property (p_irq)
    else $error("channel interrupt does not follow enabled flags");

  property p_answer;
    (psel && !penable) |=> (pready ##1 !pready);
  endproperty
  a_answer: assert property (p_answer)
    else $error("access phase not answered in one cycle");

  // ==========================================================================
  // Further checks on flag holding, the bus answer, the write paths and control storage.
  property p_half_hold;
    ((half_vec & ~clr_half) != '0) |=> ((half_vec & $past(half_vec & ~clr_half)) == $past(half_vec & ~clr_half));
  endproperty
  a_half_hold: assert property (p_half_hold)
    else $error("half-transfer flag dropped without a clear");

  property p_full_hold;
    ((full_vec & ~clr_full) != '0) |=> ((full_vec & $past(full_vec & ~clr_full)) == $past(full_vec & ~clr_full));
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full-transfer flag dropped without a clear");

  property p_unmapped;
    (psel && !penable && !hit_any) |=> (pready && pslverr && prdata == dma_flags_pkg::WORD_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_mapped;
    (psel && !penable && hit_any) |=> (pready && !pslverr);
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access answered with an error");

  property p_rdata_idle;
    !pready |-> (prdata == dma_flags_pkg::WORD_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside the answer");

  property p_ctl_free_bits;
    (done && pwrite && hit_ctl[0] && ctl[0].channel_enable) |=>
      (ctl[0][3:0] == $past(pwdata[3:0]));
  endproperty
  a_ctl_free_bits: assert property (p_ctl_free_bits)
    else $error("interrupt enables or channel enable not written while enabled");

  property p_clear_reads_zero;
    (psel && !penable && !pwrite && hit_clear) |=>
      (prdata == dma_flags_pkg::WORD_ZERO);
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("clear register read returned data");

  property p_ctl_reserved;
    (psel && !penable && !pwrite && (hit_ctl != '0)) |=>
      (prdata[31:dma_flags_pkg::CTL_USED] == '0);
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("reserved control bits read nonzero");

  property p_ctl_stable;
    !(done && pwrite && hit_ctl[1]) |=>
      (channel_config[1] == $past(channel_config[1]));
  endproperty
  a_ctl_stable: assert property (p_ctl_stable)
    else $error("control register changed without a write");

  property p_ready_after_setup;
    pready |-> $past(psel && !penable);
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("answer given without a setup cycle");

  property p_flags_write_ignored;
    (done && pwrite && hit_flags && (error_event == '0)) |=>
      (err_vec == $past(err_vec));
  endproperty
  a_flags_write_ignored: assert property (p_flags_write_ignored)
    else $error("write to the read-only flag register changed a flag");

  // Main scenarios.
  c_set_and_clear: cover property (error_event[0] && clr_err[0]);
  c_global_clear:  cover property (done && pwrite && hit_clear && pwdata[0] ##1 glob_vec[0] == 1'b0);
  c_locked_write:  cover property (done && pwrite && hit_ctl[2] && ctl[2].channel_enable);
  c_irq_raised:    cover property (channel_irq[1]);
  c_unmapped:      cover property (psel && penable && pslverr);

endmodule : dma_flags_ctrl

// *** event_engine.sv ***
/*
  Far-side model of the transfer engine: fires one set of event pulses
  after a chosen delay. Assumes commands arrive on clk from the bench.
*/
`timescale 1ns/10ps

module event_engine (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic [14:0] pattern,
  input  wire logic [3:0]  delay,
  output logic      [4:0]  error_event,
  output logic      [4:0]  half_event,
  output logic      [4:0]  full_event,
  output logic             busy
);
  logic [14:0] pend;
  logic [14:0] ev;
  logic [3:0]  cnt;
  logic        active;

  // ==========================================
  // Delay counter; a pulse lasts one cycle so a flag is set once per event.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend   <= 15'h0000;
      ev     <= 15'h0000;
      cnt    <= 4'h0;
      active <= 1'b0;
    end
    else
    begin
      ev <= 15'h0000;
      if (go && !active)
      begin
        pend   <= pattern;
        cnt    <= delay;
        active <= 1'b1;
      end
      else if (active && cnt == 4'h0)
      begin
        ev     <= pend;
        active <= 1'b0;
      end
      else if (active)
        cnt <= cnt - 4'h1;
    end
  end

  // Pattern order is error, half, full, five channels each.
  assign error_event = ev[14:10];
  assign half_event  = ev[9:5];
  assign full_event  = ev[4:0];
  assign busy        = active;
endmodule : event_engine

// *** testbench.sv ***
/*
  Self-checking bench of the DMA flag and control block with a register model.
  Assumes the event_engine partner and a zero-wait APB slave.
*/
`timescale 1ns/10ps

module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel, penable, pwrite, go;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, v;
  logic        pready, pslverr, busy;
  logic [4:0]  err_ev, half_ev, full_ev, channel_irq, m_irq;
  logic [14:0] pattern;
  logic [3:0]  dly;
  logic [2:0]  m_fl [5];
  logic [14:0] m_ctl [5];
  logic [32:0] exp_rd;
  int          n_fail, cmp_count;
  dma_flags_pkg::ctl_s [dma_flags_pkg::N_CHANNELS-1:0] channel_config;

  always #5 clk = ~clk;

  dma_flags_ctrl u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .error_event(err_ev), .half_event(half_ev), .full_event(full_ev),
    .channel_config(channel_config), .channel_irq(channel_irq));

  event_engine u_far (.clk(clk), .rst_b(rst_b), .go(go), .pattern(pattern), .delay(dly),
    .error_event(err_ev), .half_event(half_ev), .full_event(full_ev), .busy(busy));

  // ==========================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] ctl_addr(int i);
    return dma_flags_pkg::CTL_BASE + 8'(i) * dma_flags_pkg::CTL_STEP;
  endfunction : ctl_addr

  // Expected read as {slave error, data}; global bit is the OR of three.
  function automatic logic [32:0] model_read(logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 5; i++)
    begin
      w[4*i+:4] = {m_fl[i], |m_fl[i]};
      if (a == ctl_addr(i))
        return {1'b0, 17'h00000, m_ctl[i]};
    end
    if (a == dma_flags_pkg::FLAGS_OFS)
      return {1'b0, w};
    if (a == dma_flags_pkg::CLEAR_OFS)
      return 33'h0_0000_0000;
    return {1'b1, 32'h0000_0000};
  endfunction : model_read

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================
  // Register model; clears land before sets so a same-edge event survives.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 5; i++)
      begin
        m_fl[i] = 3'h0;
        m_ctl[i] = 15'h0000;
      end
      m_irq = 5'h00;
      exp_rd = 33'h0_0000_0000;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        m_irq[i] = |(m_fl[i] & m_ctl[i][3:1]);
      if (psel && !penable)
        exp_rd = model_read(paddr);
      if (psel && !penable && pwrite)
        exp_rd[31:0] = 32'h0000_0000; // Write answers carry no read data.
      for (int i = 0; i < 5; i++)
      begin
        if (psel && penable && pready && pwrite && paddr == ctl_addr(i))
          m_ctl[i] = m_ctl[i][0] ? {m_ctl[i][14:4], pwdata[3:0]} : pwdata[14:0];
        if (psel && penable && pready && pwrite && paddr == dma_flags_pkg::CLEAR_OFS)
          m_fl[i] = pwdata[4*i] ? 3'h0 : m_fl[i] & ~pwdata[4*i+1+:3];
        m_fl[i] = m_fl[i] | {err_ev[i], half_ev[i], full_ev[i]};
      end
    end
  end

  // Outputs toward the engine are checked mid-cycle, once settled.
  always @(negedge clk)
  begin
    if (rst_b)
    begin
      for (int i = 0; i < 5; i++)
        chk({17'h00000, channel_config[i]}, {17'h00000, m_ctl[i]});
      chk({27'h0000000, channel_irq}, {27'h0000000, m_irq});
    end
  end

  // ==========================================
  // Bus and partner drivers.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    chk(prdata, exp_rd[31:0]);
    chk({31'h0, pslverr}, {31'h0, exp_rd[32]});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input logic [14:0] p, input logic [3:0] d);
    @(posedge clk);
    go      <= 1'b1;
    pattern <= p;
    dly     <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy)
    begin
      @(posedge clk);
    end
  endtask : fire

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // ==========================================
  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, go, paddr, pwdata, pattern, dly} = '0;
    seed = 32'h6baf;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped offsets and a write to the read-only flags.
    foreach (m_ctl[i]) apb(1'b0, ctl_addr(i), 32'h0);
    for (int i = 0; i < 32; i++) apb(1'b0, 8'(i * 8 + 4), 32'h0);
    apb(1'b1, dma_flags_pkg::FLAGS_OFS, 32'hffff_ffff);
    // Every priority and width code on channel 0.
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, ctl_addr(0), 32'((p << 12) | (p << 10) | (p << 8)));
      apb(1'b0, ctl_addr(0), 32'h0);
    end
    // Free writes, then writes under the enable lock.
    foreach (m_ctl[i])
    begin
      apb(1'b1, ctl_addr(i), rnd() & 32'hffff_fffe);
      apb(1'b0, ctl_addr(i), 32'h0);
      apb(1'b1, ctl_addr(i), rnd() | 32'h1);
      apb(1'b1, ctl_addr(i), rnd());
      apb(1'b0, ctl_addr(i), 32'h0);
    end
    // Random events, clears and settings.
    for (int k = 0; k < 30; k++)
    begin
      apb(1'b1, ctl_addr(rnd() % 5), rnd());
      v = rnd();
      fire(v[14:0], v[19:16]);
      apb(1'b0, dma_flags_pkg::FLAGS_OFS, 32'h0);
      apb(1'b1, dma_flags_pkg::CLEAR_OFS, rnd());
      apb(1'b0, dma_flags_pkg::FLAGS_OFS, 32'h0);
    end
    // Events meeting a full clear at sliding distances.
    for (int k = 0; k < 8; k++)
    begin
      fork
        fire(15'h7fff, 4'(k));
        apb(1'b1, dma_flags_pkg::CLEAR_OFS, 32'h000f_ffff);
      join
      apb(1'b0, dma_flags_pkg::FLAGS_OFS, 32'h0);
    end
    // Second reset in mid-run.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, dma_flags_pkg::FLAGS_OFS, 32'h0);
    apb(1'b0, ctl_addr(4), 32'h0);
    test_done();
  end

  // Watchdog well beyond the thousand or so cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : testbench
